// [npsd_core.sv]
// phase accumulator, phase offset adder, sine table and dac word pipeline
// assumes writes and control bits come from logic on i_clk_sys
`timescale 1ns/1ps

// Summary of operation
// - phase held in 28-bit accumulator, full cycle spans whole range, wraps naturally.
// - output frequency equals step times clock over two to the twenty-eight.
// - two tuning words; select bit picks which feeds the accumulator step.
// - changing the selection never resets the accumulated phase.
// - two 12-bit phase offsets, each step one 4096th of a cycle.
// - selected offset is added to the accumulator's most significant bits.
// - adjusted phase truncated to its upper 12 bits for amplitude conversion.
// - truncated phase addresses a sine look-up table giving the amplitude.
// - waveform-mode bit enables or bypasses the sine table.
// - table amplitude words drive a 10-bit dac word, two bits below address.
// - a write to a selected register shows at the output 7 cycles later.
// - control bits except waveform mode are sampled on the falling clock edge.
module npsd_core
#(
  parameter int ACC_W  = npsd_pkg::ACC_W,
  parameter int OFFS_W = npsd_pkg::OFFS_W,
  parameter int ADDR_W = npsd_pkg::ADDR_W,
  parameter int DAC_W  = npsd_pkg::DAC_W
)
(
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst,
  input  wire npsd_pkg::npsd_write_t i_wr,
  input  wire npsd_pkg::npsd_ctrl_t  i_ctrl,
  output logic [DAC_W-1:0]           o_dac
);

  if (ADDR_W != DAC_W + 2 || ADDR_W > ACC_W || OFFS_W > ACC_W || ACC_W > npsd_pkg::ACC_W
      || OFFS_W != ADDR_W)
  begin : g_bad_params
    $error("npsd_core: unsupported width parameters");
  end

  localparam int LOW_W = ACC_W - OFFS_W;

  // bypass path: linear up/down ramp from the phase address
  function automatic logic [DAC_W-1:0] ramp_of(input logic [ADDR_W-1:0] a);
    logic [DAC_W-1:0] r;
    r = a[ADDR_W-2 -: DAC_W];
    if (a[ADDR_W-1])
      r = ~r;
    return r;
  endfunction

  logic [ACC_W-1:0]  tw_a;
  logic [ACC_W-1:0]  tw_b;
  logic [OFFS_W-1:0] ph_a;
  logic [OFFS_W-1:0] ph_b;
  logic [ACC_W-1:0]  next_tw_a;
  logic [ACC_W-1:0]  next_tw_b;
  logic [OFFS_W-1:0] next_ph_a;
  logic [OFFS_W-1:0] next_ph_b;

  logic              tsel_q;
  logic              psel_q;
  logic              next_tsel;
  logic              next_psel;
  logic              mode_q;
  logic              next_mode;

  logic [ACC_W-1:0]  step;
  logic [ACC_W-1:0]  acc;
  logic [OFFS_W-1:0] off_sel;
  logic [OFFS_W-1:0] off_d;
  logic [ACC_W-1:0]  phase_sum;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] addr_d;
  logic [DAC_W-1:0]  rom_q;
  logic [DAC_W-1:0]  mux_q;
  logic [ACC_W-1:0]  next_step;
  logic [ACC_W-1:0]  next_acc;
  logic [OFFS_W-1:0] next_off_sel;
  logic [OFFS_W-1:0] next_off_d;
  logic [ACC_W-1:0]  next_phase_sum;
  logic [ADDR_W-1:0] next_addr;
  logic [ADDR_W-1:0] next_addr_d;
  logic [DAC_W-1:0]  next_rom_q;
  logic [DAC_W-1:0]  next_mux;
  logic [DAC_W-1:0]  next_dac;

  logic [DAC_W-1:0]  sine_rom [1 << ADDR_W];

  // constant sine table, one entry per phase address
  for (genvar g = 0; g < (1 << ADDR_W); g++)
  begin : g_rom
    assign sine_rom[g] = DAC_W'(npsd_pkg::npsd_sine_at(g, ADDR_W, DAC_W));
  end

  // ---- word registers ----
  always_comb
  begin
    next_tw_a = tw_a;
    next_tw_b = tw_b;
    next_ph_a = ph_a;
    next_ph_b = ph_b;
    if (i_wr.valid)
    begin
      case (i_wr.target)
        npsd_pkg::NPSD_TGT_TUNE_A:  next_tw_a = i_wr.data[ACC_W-1:0];
        npsd_pkg::NPSD_TGT_TUNE_B:  next_tw_b = i_wr.data[ACC_W-1:0];
        // offsets keep only their 12 low bits
        npsd_pkg::NPSD_TGT_PHASE_A: next_ph_a = i_wr.data[OFFS_W-1:0];
        npsd_pkg::NPSD_TGT_PHASE_B: next_ph_b = i_wr.data[OFFS_W-1:0];
        default:                    next_tw_a = tw_a;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      tw_a <= npsd_pkg::TUNE_RST;
      tw_b <= npsd_pkg::TUNE_RST;
      ph_a <= npsd_pkg::OFFS_RST;
      ph_b <= npsd_pkg::OFFS_RST;
    end
    else
    begin
      tw_a <= next_tw_a;
      tw_b <= next_tw_b;
      ph_a <= next_ph_a;
      ph_b <= next_ph_b;
    end
  end

  // ---- control sampling ----
  always_comb
  begin
    next_tsel = i_ctrl.tuning_select;
    next_psel = i_ctrl.phase_select;
    next_mode = i_ctrl.mode_bypass;
  end

  // selects taken half a cycle early, stable for the rising edge
  always_ff @(negedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      tsel_q <= 1'b0;
      psel_q <= 1'b0;
    end
    else
    begin
      tsel_q <= next_tsel;
      psel_q <= next_psel;
    end
  end

  // mode is the one bit taken on the rising edge
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      mode_q <= 1'b0;
    else
      mode_q <= next_mode;
  end

  // ---- datapath ----
  always_comb
  begin
    // step from the chosen tuning word
    next_step      = tsel_q ? tw_b : tw_a;
    // modulo 2^28 add; acc never cleared on reselect
    // phase advances by step each clock, so fout = step * fclk / 2^28
    next_acc       = acc + step;
    next_off_sel   = psel_q ? ph_b : ph_a;
    // delay keeps phase writes aligned with tuning writes
    next_off_d     = off_sel;
    // offset lands on the top bits only
    next_phase_sum = acc + {off_d, {LOW_W{1'b0}}};
    next_addr      = phase_sum[ACC_W-1 -: ADDR_W];
    next_addr_d    = addr;
    next_rom_q     = sine_rom[addr];
    // table or ramp by waveform mode
    next_mux       = mode_q ? ramp_of(addr_d) : rom_q;
    next_dac       = mux_q;
  end

  // seven stages from register write to o_dac
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      step      <= npsd_pkg::TUNE_RST;
      acc       <= npsd_pkg::ACC_RST;
      off_sel   <= npsd_pkg::OFFS_RST;
      off_d     <= npsd_pkg::OFFS_RST;
      phase_sum <= npsd_pkg::ACC_RST;
      addr      <= npsd_pkg::ADDR_RST;
      addr_d    <= npsd_pkg::ADDR_RST;
      rom_q     <= npsd_pkg::DAC_RST;
      mux_q     <= npsd_pkg::DAC_RST;
      o_dac     <= npsd_pkg::DAC_RST;
    end
    else
    begin
      step      <= next_step;
      acc       <= next_acc;
      off_sel   <= next_off_sel;
      off_d     <= next_off_d;
      phase_sum <= next_phase_sum;
      addr      <= next_addr;
      addr_d    <= next_addr_d;
      rom_q     <= next_rom_q;
      mux_q     <= next_mux;
      o_dac     <= next_dac;
    end
  end

  // ---- checks ----
  chk_acc_wrap: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ##1 (acc == ACC_W'($past(acc) + $past(step))))
  else $error("accumulator did not wrap-add step");

  chk_freq_rate: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ##1 $stable(step) ##1 $stable(step)
    |-> (ACC_W'(acc - $past(acc, 2)) == ACC_W'(step << 1)))
  else $error("phase rate not step per clock");

  chk_step_select: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ##1 (step == ($past(tsel_q) ? $past(tw_b) : $past(tw_a))))
  else $error("step not from selected tuning word");

  chk_phase_cont: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    $changed(tsel_q)
    |=> (acc == ACC_W'($past(acc) + $past(step)))
        && (acc != '0 || $past(acc) != '0 || $past(step) == '0))
  else $error("phase jumped on select change");

  chk_offset_add: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ##1 (phase_sum == ACC_W'($past(acc) + {$past(off_d), {LOW_W{1'b0}}})))
  else $error("offset not on top bits");

  chk_trunc_addr: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ##2 (addr == $past(acc[ACC_W-1 -: ADDR_W] + off_d, 2)))
  else $error("address not upper 12 bits of sum");

  chk_rom_lookup: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ##1 (rom_q == $past(sine_rom[addr])))
  else $error("table output wrong");

  chk_mode_mux: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ##2 (mux_q == ($past(mode_q) ? ramp_of($past(addr, 2)) : $past(sine_rom[addr], 2))))
  else $error("waveform mode select wrong");

  chk_dac_pass: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ##3 (o_dac == $past(rom_q, 2) || $past(mode_q, 2)))
  else $error("dac word not from table");

  chk_write_latency: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_wr.valid && i_wr.target == npsd_pkg::NPSD_TGT_PHASE_A && !psel_q)
      ##1 !psel_q ##1 !psel_q
    |-> ##2 (phase_sum[ACC_W-1 -: ADDR_W]
            == ADDR_W'($past(acc[ACC_W-1 -: ADDR_W]) + $past(i_wr.data[OFFS_W-1:0], 4))))
  else $error("phase write latency wrong");

  chk_fall_sample: assert property (
    @(negedge i_clk_sys) disable iff (i_rst)
    ##1 (tsel_q == $past(i_ctrl.tuning_select)) && (psel_q == $past(i_ctrl.phase_select)))
  else $error("select not sampled on falling edge");

  chk_pipe_order: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ##2 (acc == ACC_W'($past(acc, 2) + $past(step, 2) + $past(step))))
  else $error("accumulator skipped a cycle");

endmodule

// [npsd_pkg.sv]
// constants, types and the sine table generator for the nco datapath
// assumes a single system clock; host logic drives writes on that clock
package npsd_pkg;

  localparam int ACC_W       = 28;
  localparam int OFFS_W      = 12;
  localparam int ADDR_W      = 12;
  localparam int DAC_W       = 10;
  localparam int WR_LATENCY  = 7;

  localparam logic [ACC_W-1:0]  ACC_RST  = 28'h0000000;
  localparam logic [ACC_W-1:0]  TUNE_RST = 28'h0000000;
  localparam logic [OFFS_W-1:0] OFFS_RST = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [DAC_W-1:0]  DAC_RST  = 10'h200;

  typedef enum logic [1:0]
  {
    NPSD_TGT_TUNE_A  = 2'h0,
    NPSD_TGT_TUNE_B  = 2'h1,
    NPSD_TGT_PHASE_A = 2'h2,
    NPSD_TGT_PHASE_B = 2'h3
  } npsd_target_t;

  typedef struct packed
  {
    logic             valid;
    npsd_target_t     target;
    logic [ACC_W-1:0] data;
  } npsd_write_t;

  typedef struct packed
  {
    logic tuning_select;
    logic phase_select;
    logic mode_bypass;
  } npsd_ctrl_t;

  // integer sine approximation, offset binary around midscale
  function automatic longint npsd_sine_at(input int idx, input int addr_w, input int dac_w);
    longint half;
    longint p;
    longint u;
    longint amp;
    longint mid;
    half = longint'(1) << (addr_w - 1);
    mid  = longint'(1) << (dac_w - 1);
    p    = longint'(idx) % half;
    u    = p * (half - p);
    amp  = ((mid - 1) * 16 * u) / (5 * half * half - 4 * u);
    if (longint'(idx) < half)
      return mid + amp;
    return mid - amp;
  endfunction

endpackage

// [npsd_host.sv]
// host model: loads tuning and phase words and drives the control levels
// assumes every task is entered on a falling edge of i_clk_sys
`timescale 1ns/1ps
module npsd_host
(
  input  wire logic             i_clk_sys,
  output npsd_pkg::npsd_write_t o_wr,
  output npsd_pkg::npsd_ctrl_t  o_ctrl
);
  initial
  begin
    o_wr   = '0;
    o_ctrl = '0;
  end

  // one word per call, valid for exactly one rising edge
  task automatic write_word(input npsd_pkg::npsd_target_t tgt,
                            input logic [npsd_pkg::ACC_W-1:0] data);
    o_wr <= '{valid: 1'b1, target: tgt, data: data};
    @(negedge i_clk_sys);
    // released bus shows inverted content, so stale data cannot pass for a write
    o_wr <= '{valid: 1'b0, target: npsd_pkg::npsd_target_t'(~tgt), data: ~data};
  endtask

  task automatic set_ctrl(input logic tsel, input logic psel, input logic byp);
    o_ctrl <= '{tuning_select: tsel, phase_select: psel, mode_bypass: byp};
  endtask
endmodule

// [tb.sv]
// self-checking bench for the nco datapath
// assumes the design carries its own assertions; host model drives writes and control levels, bench drives clock and reset
`timescale 1ns/1ps
`define CHK(name, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("Error %s expected %h seen %h", name, exp, got); \
    end \
  end

module tb;
  localparam int LIMIT = 1000;
  logic                  i_clk_sys;
  logic                  i_rst;
  npsd_pkg::npsd_write_t wr;
  npsd_pkg::npsd_ctrl_t  ctrl;
  logic [9:0]            o_dac;
  int                    n_fail;
  int                    n_checks;
  int                    cycles;

  npsd_core i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wr(wr), .i_ctrl(ctrl), .o_dac(o_dac));
  npsd_host i_host (.i_clk_sys(i_clk_sys), .o_wr(wr), .o_ctrl(ctrl));

  always #2.5 i_clk_sys = ~i_clk_sys;

  task automatic tick(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask

  // ramp word for a quarter-cycle index with offset 0x100, so all four differ
  function automatic logic [9:0] ramp_q(input logic [1:0] q);
    logic [11:0] a;
    a = {q, 10'h100};
    return a[11] ? ~a[10:1] : a[10:1];
  endfunction

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_fail++;
      $display("Error timeout expected %0d seen %0d", LIMIT, cycles);
      end_of_test();
    end
  end

  task automatic t_reset_mode;
    tick(3);
    `CHK("dac idle", 10'h200, o_dac)
    i_host.set_ctrl(1'b0, 1'b0, 1'b1);
    // mode taken at the next rising edge, seen two edges later
    tick(2);
    `CHK("mode early", 10'h200, o_dac)
    tick(1);
    `CHK("mode ramp", 10'h000, o_dac)
    i_host.set_ctrl(1'b0, 1'b0, 1'b0);
    tick(3);
    $display("test reset_mode done");
  endtask

  task automatic t_phase;
    // upper data bits must not leak into the 12-bit offset
    i_host.write_word(npsd_pkg::NPSD_TGT_PHASE_A, 28'h5555400);
    tick(6);
    `CHK("phase a early", 10'h200, o_dac)
    tick(1);
    `CHK("phase a quarter", 10'h3ff, o_dac)
    i_host.write_word(npsd_pkg::NPSD_TGT_PHASE_B, 28'h0000c00);
    tick(8);
    `CHK("phase b unselected", 10'h3ff, o_dac)
    i_host.set_ctrl(1'b0, 1'b1, 1'b0);
    tick(7);
    `CHK("phase sel early", 10'h3ff, o_dac)
    tick(1);
    `CHK("phase b three quarter", 10'h001, o_dac)
    $display("test phase done");
  endtask

  task automatic t_freq;
    logic [1:0] q;
    i_host.set_ctrl(1'b0, 1'b0, 1'b1);
    i_host.write_word(npsd_pkg::NPSD_TGT_PHASE_A, 28'h0000100);
    tick(1);
    i_host.write_word(npsd_pkg::NPSD_TGT_TUNE_B, 28'h8000000);
    tick(8);
    `CHK("ramp offset", ramp_q(2'h0), o_dac)
    i_host.write_word(npsd_pkg::NPSD_TGT_TUNE_A, 28'h4000000);
    tick(6);
    `CHK("tune a early", ramp_q(2'h0), o_dac)
    tick(1);
    `CHK("tune a step", ramp_q(2'h1), o_dac)
    q = 2'h1;
    // quarter step: period of four clocks, wraps through the whole range
    for (int k = 0; k < 8; k++)
    begin
      tick(1);
      q = q + 2'h1;
      `CHK("quarter stream", ramp_q(q), o_dac)
    end
    i_host.set_ctrl(1'b1, 1'b0, 1'b1);
    for (int k = 1; k <= 12; k++)
    begin
      tick(1);
      q = q + ((k >= 8) ? 2'h2 : 2'h1);
      `CHK("select continuity", ramp_q(q), o_dac)
    end
    $display("test freq done");
  endtask

  initial
  begin
    i_clk_sys = 1'b0;
    i_rst     = 1'b1;
    n_fail    = 0;
    n_checks  = 0;
    cycles    = 0;
    tick(4);
    `CHK("dac in reset", 10'h200, o_dac)
    tick(4);
    // non-blocking: the falling-edge select flops must not race the release
    i_rst <= 1'b0;
    t_reset_mode();
    t_phase();
    t_freq();
    end_of_test();
  end
endmodule
